// *** hcs_pkg.sv ***
// Constants for the hub charger, suspend and squelch configuration slice.
package hcs_pkg;
    localparam logic [7:0] HCS_ADDR_ALT_TARGET = 8'h00_eb;
    localparam logic [7:0] HCS_ADDR_CHG_MODE   = 8'h00_ec;
    localparam logic [7:0] HCS_ADDR_CHG_MASK   = 8'h00_ed;
    localparam logic [7:0] HCS_ADDR_HUB_CFG    = 8'h00_ee;
    localparam logic [7:0] HCS_ADDR_SQUELCH    = 8'h00_f4;

    localparam logic [7:0] HCS_RST_ALT_TARGET  = 8'h00_28;
    localparam logic [7:0] HCS_RST_CHG_MODE    = 8'h00_14;
    localparam logic [7:0] HCS_RST_CHG_MASK    = 8'h00_0f;
    localparam logic [1:0] HCS_RST_HUB_CFG     = 2'h0;
    localparam logic [2:0] HCS_RST_SQUELCH     = 3'h0;

    localparam int HCS_ADDR_LSB      = 1;
    localparam int HCS_ADDR_MSB      = 6;
    localparam int HCS_CHG_EN_BIT    = 4;
    localparam int HCS_ENH_BIT       = 2;
    localparam int HCS_CDP_MASK_BIT  = 1;
    localparam int HCS_DCP_MASK_BIT  = 0;
    localparam int HCS_MASK_RSV_LSB  = 2;
    localparam int HCS_MASK_RSV_MSB  = 3;
    localparam int HCS_KEEPALIVE_BIT = 7;
    localparam int HCS_SUSP_ROLE_BIT = 6;
    localparam int HCS_TOUT_LSB      = 4;
    localparam int HCS_TOUT_MSB      = 5;
    localparam int HCS_UP_SQ_LSB     = 4;
    localparam int HCS_UP_SQ_MSB     = 6;
    localparam int HCS_DN3_SQ_LSB    = 0;
    localparam int HCS_DN3_SQ_MSB    = 2;

    localparam int HCS_SYNC_STAGES   = 2;
    localparam int HCS_READ_LATENCY  = 1;

    typedef enum logic [2:0] {
        HCS_SQ_NOMINAL,
        HCS_SQ_90,
        HCS_SQ_80,
        HCS_SQ_70,
        HCS_SQ_60,
        HCS_SQ_50,
        HCS_SQ_120,
        HCS_SQ_110
    } hcs_squelch_t;
endpackage : hcs_pkg

// *** hcs_sync.sv ***
// Two-flop synchroniser for a single pin level.
module hcs_sync
    import hcs_pkg::*;
(
    input  wire logic clk,   // System clock.
    input  wire logic rst,   // Asynchronous reset, active high.
    input  wire logic ce,    // Clock enable.
    input  wire logic pin,   // Asynchronous pin level.
    output logic      level  // Synchronised level.
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta  <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            meta  <= pin;
            level <= meta;
        end
    end
endmodule // hcs_sync

// *** hcs_chg_flag.sv ***
// Charger-detected flag and its sticky interrupt status bit.
module hcs_chg_flag
    import hcs_pkg::*;
(
    input  wire logic clk,          // System clock.
    input  wire logic rst,          // Asynchronous reset, active high.
    input  wire logic ce,           // Clock enable.
    input  wire logic cdp_found,    // Charging downstream port detected.
    input  wire logic dcp_found,    // Dedicated charging port detected.
    input  wire logic cdp_mask,     // Let a CDP detection drive the flag.
    input  wire logic dcp_mask,     // Let a DCP detection drive the flag.
    input  wire logic flag_release, // Return the flag high.
    input  wire logic status_clear, // Host writes zero to the status bit.
    output logic      flag_n,       // Charger detected, active low.
    output logic      irq_status    // Sticky flag-asserted status.
);
    logic assert_flag;

    assign assert_flag = (cdp_found && cdp_mask)
                      || (dcp_found && dcp_mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_n <= 1'b1;
        end else if (ce) begin
            if (assert_flag) begin
                flag_n <= 1'b0;
            end else if (flag_release) begin
                flag_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 1'b0;
        end else if (ce) begin
            if (assert_flag) begin
                irq_status <= 1'b1;
            end else if (status_clear) begin
                irq_status <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    cdp_masked_a: assert property (ce && cdp_found && cdp_mask
        |=> !flag_n && irq_status)
        else $error("masked CDP detection did not assert the flag");
    dcp_off_a: assert property (ce && dcp_found && !dcp_mask && !cdp_found
        && flag_n && !flag_release |=> flag_n)
        else $error("unmasked DCP detection changed the flag");
    status_hold_a: assert property (ce && irq_status && !status_clear
        |=> irq_status)
        else $error("charger status bit dropped without a clear");
endmodule // hcs_chg_flag

// *** hcs_regs.sv ***
// Charger, suspend and squelch configuration registers of the hub.
// How it works
// - Offset EB reads a fixed upper target address 0x28 used when the high select pin is set.
// - Address bits 7 and 0 read zero; the low address bit comes from the low select pin.
// - With detection enabled, detection starts on entering its stage or in the reference wait without a clock.
// - The enhanced bit makes the routine reverse the data-line source.
// - The charger mode register resets to 0x14.
// - With the CDP mask set, a CDP detection drives the flag low; otherwise it leaves it alone.
// - With the DCP mask set, a DCP detection drives the flag low; otherwise it leaves it alone.
// - The charger mask register resets to 0x0F.
// - The keep-alive bit stops the internal clocks from being gated in suspend.
// - The role bit turns the interrupt pin into a level suspend indicator.
// - Bits 5:4 of the hub config register report the configuration time-out, read only.
// - Bits 6:4 of the squelch register select the upstream squelch threshold.
// - Bits 2:0 of the squelch register select the downstream port 3 threshold.
// - The charger status bit sets when the flag goes low and holds until cleared.
module hcs_regs
    import hcs_pkg::*;
(
    input  wire logic       clk,             // System clock, 20 MHz.
    input  wire logic       rst,             // Asynchronous reset.
    input  wire logic       ce,              // Clock enable.
    input  wire logic [7:0] reg_addr,        // Register offset.
    input  wire logic [7:0] reg_wdata,       // Write data.
    input  wire logic       reg_we,          // Write strobe.
    input  wire logic       reg_re,          // Read strobe.
    output logic      [7:0] reg_rdata,       // Read data.
    output logic            reg_rvalid,      // Read data valid.
    input  wire logic       address_select_high_pin, // Address pin 1.
    input  wire logic       address_select_low_pin,  // Address pin 0.
    input  wire logic [5:0] primary_addr_upper, // Upper bits, pin low.
    output logic      [6:0] target_address,  // Active target address.
    input  wire logic       charger_detect_stage, // Detection stage.
    input  wire logic       refclock_wait_stage,  // Reference wait.
    input  wire logic       refclock_present, // Reference clock seen.
    output logic            charger_detect_start, // Start pulse.
    output logic            enhanced_charger_detect, // Reverse source.
    input  wire logic       cdp_found,       // CDP detected pulse.
    input  wire logic       dcp_found,       // DCP detected pulse.
    input  wire logic       flag_release,    // Return flag high.
    input  wire logic       status_clear,    // Clear charger status.
    output logic            charger_detected_flag_n, // Flag, low active.
    output logic            charger_detect_irq_status, // Sticky status.
    input  wire logic [1:0] config_timeout_value, // Time-out code.
    input  wire logic       hub_suspended,   // Hub in bus suspend.
    input  wire logic       serial_irq_pending, // Serial port event.
    output logic            internal_clock_gate, // Gate clocks off.
    output logic            irq_pin_n,       // Interrupt pin level.
    output logic      [2:0] up_squelch_select, // Upstream squelch.
    output logic      [2:0] downstream3_squelch_select // Port 3.
);
    logic       charger_detect_enable;
    logic       charging_port_detect_mask;
    logic       dedicated_charger_detect_mask;
    logic       suspend_clock_keepalive;
    logic       irq_pin_suspend_role;
    logic       sel_high;
    logic       sel_low;
    logic       stage_prev;
    logic       start_cond;
    logic [7:0] next_rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    hcs_sync u_sync_high (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .pin   (address_select_high_pin),
        .level (sel_high)
    );

    hcs_sync u_sync_low (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .pin   (address_select_low_pin),
        .level (sel_low)
    );

    hcs_chg_flag u_flag (
        .clk          (clk),
        .rst          (rst),
        .ce           (ce),
        .cdp_found    (cdp_found),
        .dcp_found    (dcp_found),
        .cdp_mask     (charging_port_detect_mask),
        .dcp_mask     (dedicated_charger_detect_mask),
        .flag_release (flag_release),
        .status_clear (status_clear),
        .flag_n       (charger_detected_flag_n),
        .irq_status   (charger_detect_irq_status)
    );

    // Charger mode: only the enable and enhanced bits hold state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charger_detect_enable   <= HCS_RST_CHG_MODE[HCS_CHG_EN_BIT];
            enhanced_charger_detect <= HCS_RST_CHG_MODE[HCS_ENH_BIT];
        end else if (ce && reg_we && hit(reg_addr, HCS_ADDR_CHG_MODE)) begin
            charger_detect_enable   <= reg_wdata[HCS_CHG_EN_BIT];
            enhanced_charger_detect <= reg_wdata[HCS_ENH_BIT];
        end
    end

    // The CDP mask is stored as written; software pairs it with enhanced
    // detection, since without it a CDP is never reported.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charging_port_detect_mask     <= HCS_RST_CHG_MASK[HCS_CDP_MASK_BIT];
            dedicated_charger_detect_mask <= HCS_RST_CHG_MASK[HCS_DCP_MASK_BIT];
        end else if (ce && reg_we && hit(reg_addr, HCS_ADDR_CHG_MASK)) begin
            charging_port_detect_mask     <= reg_wdata[HCS_CDP_MASK_BIT];
            dedicated_charger_detect_mask <= reg_wdata[HCS_DCP_MASK_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            suspend_clock_keepalive <= HCS_RST_HUB_CFG[1];
            irq_pin_suspend_role    <= HCS_RST_HUB_CFG[0];
        end else if (ce && reg_we && hit(reg_addr, HCS_ADDR_HUB_CFG)) begin
            suspend_clock_keepalive <= reg_wdata[HCS_KEEPALIVE_BIT];
            irq_pin_suspend_role    <= reg_wdata[HCS_SUSP_ROLE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_squelch_select          <= HCS_RST_SQUELCH;
            downstream3_squelch_select <= HCS_RST_SQUELCH;
        end else if (ce && reg_we && hit(reg_addr, HCS_ADDR_SQUELCH)) begin
            up_squelch_select          <= reg_wdata[HCS_UP_SQ_MSB:HCS_UP_SQ_LSB];
            downstream3_squelch_select <= reg_wdata[HCS_DN3_SQ_MSB:HCS_DN3_SQ_LSB];
        end
    end

    // Detection starts once per entry to its stage, or every cycle of the
    // reference wait while no reference clock is present.
    assign start_cond = charger_detect_enable
        && ((charger_detect_stage && !stage_prev)
        || (refclock_wait_stage && !refclock_present));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_prev           <= 1'b0;
            charger_detect_start <= 1'b0;
        end else if (ce) begin
            stage_prev           <= charger_detect_stage;
            charger_detect_start <= start_cond;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            target_address <= 7'h00;
        end else if (ce) begin
            target_address <= {sel_high
                ? HCS_RST_ALT_TARGET[HCS_ADDR_MSB:HCS_ADDR_LSB]
                : primary_addr_upper, sel_low};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            internal_clock_gate <= 1'b0;
            irq_pin_n           <= 1'b1;
        end else if (ce) begin
            internal_clock_gate <= hub_suspended && !suspend_clock_keepalive;
            irq_pin_n <= irq_pin_suspend_role ? !hub_suspended
                                              : !serial_irq_pending;
        end
    end

    // Reserved bits are built as zeros; mask bits 3:2 keep their reset ones.
    always_comb begin
        next_rdata = 8'h00;
        if (hit(reg_addr, HCS_ADDR_ALT_TARGET)) begin
            next_rdata = HCS_RST_ALT_TARGET;
        end else if (hit(reg_addr, HCS_ADDR_CHG_MODE)) begin
            next_rdata[HCS_CHG_EN_BIT] = charger_detect_enable;
            next_rdata[HCS_ENH_BIT]    = enhanced_charger_detect;
        end else if (hit(reg_addr, HCS_ADDR_CHG_MASK)) begin
            next_rdata[HCS_MASK_RSV_MSB:HCS_MASK_RSV_LSB] =
                HCS_RST_CHG_MASK[HCS_MASK_RSV_MSB:HCS_MASK_RSV_LSB];
            next_rdata[HCS_CDP_MASK_BIT] = charging_port_detect_mask;
            next_rdata[HCS_DCP_MASK_BIT] = dedicated_charger_detect_mask;
        end else if (hit(reg_addr, HCS_ADDR_HUB_CFG)) begin
            next_rdata[HCS_KEEPALIVE_BIT] = suspend_clock_keepalive;
            next_rdata[HCS_SUSP_ROLE_BIT] = irq_pin_suspend_role;
            next_rdata[HCS_TOUT_MSB:HCS_TOUT_LSB] = config_timeout_value;
        end else if (hit(reg_addr, HCS_ADDR_SQUELCH)) begin
            next_rdata[HCS_UP_SQ_MSB:HCS_UP_SQ_LSB]   = up_squelch_select;
            next_rdata[HCS_DN3_SQ_MSB:HCS_DN3_SQ_LSB] =
                downstream3_squelch_select;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_re;
            if (reg_re) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence alt_read_s;
        ce && reg_re && hit(reg_addr, HCS_ADDR_ALT_TARGET);
    endsequence

    sequence mode_write_s;
        ce && reg_we && hit(reg_addr, HCS_ADDR_CHG_MODE);
    endsequence

    alt_addr_read_a: assert property (alt_read_s |=> reg_rdata == 8'h00_28
        && reg_rvalid)
        else $error("alternate address did not read 0x28");
    addr_pin_map_a: assert property (ce [*3] ##0 $stable(sel_high)
        ##0 $stable(sel_low) |=> target_address[0] == $past(sel_low))
        else $error("address low bit does not follow the select pin");
    mode_rw_a: assert property (mode_write_s ##1 ce && reg_re
        && hit(reg_addr, HCS_ADDR_CHG_MODE) && !reg_we
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h00_14))
        else $error("charger mode readback wrong");
    start_on_entry_a: assert property (ce && charger_detect_enable
        && charger_detect_stage && !stage_prev |=> charger_detect_start)
        else $error("detection did not start on stage entry");
    no_start_off_a: assert property (ce && !charger_detect_enable
        |=> !charger_detect_start)
        else $error("detection started while disabled");
    enh_write_a: assert property (mode_write_s
        |=> enhanced_charger_detect == $past(reg_wdata[HCS_ENH_BIT]))
        else $error("enhanced bit did not take the write");
    clock_gate_a: assert property (ce && hub_suspended
        && suspend_clock_keepalive |=> !internal_clock_gate)
        else $error("clock gated while keep-alive set");
    susp_role_a: assert property (ce && irq_pin_suspend_role
        |=> irq_pin_n == !$past(hub_suspended))
        else $error("interrupt pin not tracking suspend");
    squelch_wr_a: assert property (ce && reg_we
        && hit(reg_addr, HCS_ADDR_SQUELCH)
        |=> up_squelch_select == $past(reg_wdata[6:4]))
        else $error("upstream squelch select not written");
    dn3_wr_a: assert property (ce && reg_we
        && hit(reg_addr, HCS_ADDR_SQUELCH)
        |=> downstream3_squelch_select == $past(reg_wdata[2:0]))
        else $error("port 3 squelch select not written");
    tout_read_a: assert property (ce && reg_re
        && hit(reg_addr, HCS_ADDR_HUB_CFG)
        |=> reg_rdata[5:4] == $past(config_timeout_value))
        else $error("time-out field readback wrong");
    rst_vals_a: assert property ($fell(rst) |-> charger_detect_enable
        && enhanced_charger_detect && charging_port_detect_mask
        && dedicated_charger_detect_mask)
        else $error("mode or mask reset value wrong");
endmodule // hcs_regs

// *** hcs_det_model.sv ***
// Behavioural charger detection routine that answers the start request.
module hcs_det_model
    import hcs_pkg::*;
(
    input  wire logic       clk,       // System clock.
    input  wire logic       rst,       // Asynchronous reset, active high.
    input  wire logic       start,     // Detection start request.
    input  wire logic       enhanced,  // Reversed data-line source.
    input  wire logic [1:0] kind,      // Attached charger: 1 CDP, 2 DCP.
    output logic            cdp_found, // CDP detected pulse.
    output logic            dcp_found  // DCP detected pulse.
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cdp_found <= 1'b0;
            dcp_found <= 1'b0;
        end else begin
            // Without the reversed source a CDP cannot be told apart.
            cdp_found <= start && kind == 2'h1 && enhanced;
            dcp_found <= start && kind == 2'h2;
        end
    end
endmodule // hcs_det_model

// *** tb_hcs_regs.sv ***
// Self-checking testbench for the charger and squelch register slice.
module tb_hcs_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import hcs_pkg::*;
    logic       clk, rst, ce, we, re, hi_pin, lo_pin, stage, rwait;
    logic       refclk, rel, sclr, susp, sirq, rvalid, start, enh;
    logic       cdp, dcp, flag_n, irq_st, gate, irq_n;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] prim;
    logic [1:0] tout, kind;
    logic [6:0] taddr;
    logic [2:0] upsq, dnsq;
    int         error_cnt, checks_done, cyc;

    hcs_regs DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr),
        .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .address_select_high_pin(hi_pin),
        .address_select_low_pin(lo_pin), .primary_addr_upper(prim),
        .target_address(taddr), .charger_detect_stage(stage),
        .refclock_wait_stage(rwait), .refclock_present(refclk),
        .charger_detect_start(start), .enhanced_charger_detect(enh),
        .cdp_found(cdp), .dcp_found(dcp), .flag_release(rel),
        .status_clear(sclr), .charger_detected_flag_n(flag_n),
        .charger_detect_irq_status(irq_st), .config_timeout_value(tout),
        .hub_suspended(susp), .serial_irq_pending(sirq),
        .internal_clock_gate(gate), .irq_pin_n(irq_n),
        .up_squelch_select(upsq), .downstream3_squelch_select(dnsq));
    hcs_det_model u_det (.clk(clk), .rst(rst), .start(start),
        .enhanced(enh), .kind(kind), .cdp_found(cdp), .dcp_found(dcp));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // Read data is looked at in the single cycle that rvalid stands.
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a; re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        chk("rvalid", 8'h00_01, {7'h0, rvalid});
        chk(n, e, rdata);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset;
        rc("addr1", HCS_ADDR_ALT_TARGET, 8'h00_28);
        rc("mode", HCS_ADDR_CHG_MODE, 8'h00_14);
        rc("mask", HCS_ADDR_CHG_MASK, 8'h00_0f);
        rc("cfg", HCS_ADDR_HUB_CFG, {2'h0, tout, 4'h0});
        rc("squelch", HCS_ADDR_SQUELCH, 8'h00_00);
        rc("unmapped", 8'h00_f0, 8'h00_00);
        $display("test reset_values done");
    endtask
    task automatic t_writes;
        wr(HCS_ADDR_ALT_TARGET, 8'h00_ff);
        rc("addr1", HCS_ADDR_ALT_TARGET, 8'h00_28);
        wr(HCS_ADDR_CHG_MODE, 8'h00_eb);
        rc("mode", HCS_ADDR_CHG_MODE, 8'h00_00);
        chk("enhanced", 8'h00_00, {7'h0, enh});
        // Write followed at once by a read of the same register.
        @(posedge clk);
        addr <= HCS_ADDR_CHG_MODE; wdata <= 8'h00_04; we <= 1'b1;
        @(posedge clk);
        we <= 1'b0; re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        chk("mode_b2b", 8'h00_04, rdata);
        wr(HCS_ADDR_CHG_MODE, 8'h00_ff);
        rc("mode", HCS_ADDR_CHG_MODE, 8'h00_14);
        chk("enhanced", 8'h00_01, {7'h0, enh});
        wr(HCS_ADDR_CHG_MASK, 8'h00_f0);
        rc("mask", HCS_ADDR_CHG_MASK, 8'h00_0c);
        wr(HCS_ADDR_HUB_CFG, 8'h00_ff);
        rc("cfg", HCS_ADDR_HUB_CFG, {2'h3, tout, 4'h0});
        $display("test write_access done");
    endtask
    task automatic t_squelch;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(HCS_ADDR_SQUELCH, {1'b1, c, 1'b1, ~c});
            rc("squelch", HCS_ADDR_SQUELCH, {1'b0, c, 1'b0, ~c});
            chk("up_squelch", {5'h0, c}, {5'h0, upsq});
            chk("downstream3_squelch_select", {5'h0, ~c}, {5'h0, dnsq});
        end
        $display("test squelch done");
    endtask
    task automatic t_suspend;
        wr(HCS_ADDR_HUB_CFG, 8'h00_00);
        @(posedge clk);
        susp <= 1'b1; sirq <= 1'b1;
        settle;
        chk("clock_gate", 8'h00_01, {7'h0, gate});
        chk("irq_pin_n", 8'h00_00, {7'h0, irq_n});
        @(posedge clk);
        sirq <= 1'b0;
        settle;
        chk("irq_pin_n", 8'h00_01, {7'h0, irq_n});
        wr(HCS_ADDR_HUB_CFG, 8'h00_c0);
        settle;
        chk("clock_gate", 8'h00_00, {7'h0, gate});
        chk("irq_pin_n", 8'h00_00, {7'h0, irq_n});
        @(posedge clk);
        susp <= 1'b0;
        settle;
        chk("irq_pin_n", 8'h00_01, {7'h0, irq_n});
        wr(HCS_ADDR_HUB_CFG, 8'h00_00);
        $display("test suspend done");
    endtask
    task automatic det(input logic [1:0] k, input logic [7:0] md,
                       input logic [7:0] mk, input logic es, input logic ef);
        wr(HCS_ADDR_CHG_MODE, md);
        wr(HCS_ADDR_CHG_MASK, mk);
        @(posedge clk);
        kind <= k; stage <= 1'b1;
        @(posedge clk);
        stage <= 1'b0;
        @(negedge clk);
        chk("start", {7'h0, es}, {7'h0, start});
        settle;
        chk("flag_n", {7'h0, ef}, {7'h0, flag_n});
        chk("irq_status", {7'h0, ~ef}, {7'h0, irq_st});
        @(posedge clk);
        rel <= 1'b1; sclr <= 1'b1;
        @(posedge clk);
        rel <= 1'b0; sclr <= 1'b0;
        settle;
        chk("flag_n", 8'h00_01, {7'h0, flag_n});
        chk("irq_status", 8'h00_00, {7'h0, irq_st});
    endtask
    task automatic t_charger;
        det(2'h1, 8'h00_14, 8'h00_03, 1'b1, 1'b0);
        det(2'h1, 8'h00_14, 8'h00_01, 1'b1, 1'b1);
        det(2'h2, 8'h00_10, 8'h00_01, 1'b1, 1'b0);
        det(2'h2, 8'h00_14, 8'h00_02, 1'b1, 1'b1);
        det(2'h2, 8'h00_04, 8'h00_01, 1'b0, 1'b1);
        @(posedge clk);
        kind <= 2'h0; rwait <= 1'b1;
        settle;
        chk("start_wait", 8'h00_00, {7'h0, start});
        wr(HCS_ADDR_CHG_MODE, 8'h00_10);
        settle;
        chk("start_wait", 8'h00_01, {7'h0, start});
        @(posedge clk);
        refclk <= 1'b1;
        settle;
        chk("start_wait", 8'h00_00, {7'h0, start});
        @(posedge clk);
        rwait <= 1'b0;
        $display("test charger_detect done");
    endtask
    task automatic t_address;
        @(posedge clk);
        hi_pin <= 1'b1; lo_pin <= 1'b1; prim <= 6'h05;
        settle;
        chk("target_address", 8'h00_29, {1'b0, taddr});
        @(posedge clk);
        hi_pin <= 1'b0; lo_pin <= 1'b0;
        settle;
        chk("target_address", 8'h00_0a, {1'b0, taddr});
        $display("test target_address done");
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize;
        end
    end

    initial begin
        rst = 1'b1; ce = 1'b1; we = 1'b0; re = 1'b0; addr = 8'h00_00;
        wdata = 8'h00_00; hi_pin = 1'b0; lo_pin = 1'b0; prim = 6'h00;
        stage = 1'b0; rwait = 1'b0; refclk = 1'b0; rel = 1'b0;
        sclr = 1'b0; susp = 1'b0; sirq = 1'b0; tout = 2'h2; kind = 2'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_writes;
        t_squelch;
        t_suspend;
        t_charger;
        t_address;
        summarize;
    end
endmodule // tb_hcs_regs
